// ===== common/ssp_pkg.sv
// Constants and types for the serial position slave
package ssp_pkg;
    // Position word and resolution limits, in bits (4 .. 262144 increments)
    localparam int POS_W = 18;
    localparam logic [4:0] MIN_BITS = 5'h02;
    localparam logic [4:0] MAX_BITS = 5'h12;
    // Timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int MONO_TIME_NS = 25000;
    // Longest time, so the cycle count rounds down
    localparam logic [10:0] MONO_CYC = 11'(MONO_TIME_NS / CLK_PERIOD_NS);
    // Reset values and buffer depth
    localparam logic DATA_IDLE = 1'b1;
    localparam logic SCLK_IDLE = 1'b1;
    localparam logic [1:0] BUF_DEPTH = 2'h2;

    // Transfer states, Gray coded along idle -> shift -> drain
    typedef enum logic [1:0]
    {
        SSP_IDLE = 2'b00,
        SSP_SHIFT = 2'b01,
        SSP_DRAIN = 2'b11
    } ssp_state_e;

    typedef struct packed
    {
        logic sclk_meta;
        logic sclk_sync;
        logic sclk_prev;
        ssp_state_e state;
        logic [10:0] mono;
        logic [4:0] word_len;
        logic [4:0] bits_left;
        logic [POS_W-1:0] shreg;
        logic data;
        logic [POS_W-1:0] buf0;
        logic [POS_W-1:0] buf1;
        logic [1:0] cnt;
    } ssp_regs_s;
endpackage : ssp_pkg

// ===== core/ssp_slave.sv
// Synchronous serial position slave with monoflop and input buffer
`timescale 1ns/1ps

// How it works
// - While idle the shift register keeps loading the oldest buffered position sample.
// - The first falling serial clock edge starts the monoflop and freezes the register.
// - Each following rising edge puts out one bit, most significant bit first.
// - Every serial clock edge in the burst retriggers the monoflop.
// - A rising edge after the last bit drives the data line low until the monoflop runs out, then loading resumes.
// - The word width follows the configured resolution, 4 to 262144 increments.
module ssp_slave
    import ssp_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Link pins
    input wire logic sclk_in,
    output logic data_out,
    // Configuration: word width in bits for the set resolution
    input wire logic [4:0] res_bits,
    // Position sample stream
    input wire logic [POS_W-1:0] pos_in,
    input wire logic pos_valid,
    output logic pos_ready,
    // Status
    output logic busy
);
    ssp_regs_s r_reg;
    ssp_regs_s r_next;
    logic fall;
    logic rise;
    logic cur_bit;
    logic pop;
    logic push;

    // Edge detection on the synchronised link clock only
    assign fall = r_reg.sclk_prev & ~r_reg.sclk_sync;
    assign rise = ~r_reg.sclk_prev & r_reg.sclk_sync;
    assign cur_bit = (r_reg.bits_left != 5'h00) ?
        r_reg.shreg[5'(r_reg.bits_left - 5'h01)] : 1'b0;

    // Buffer stalls the source while a frozen transfer blocks draining
    assign pos_ready = (r_reg.cnt != BUF_DEPTH);
    assign push = pos_valid & pos_ready;
    assign pop = (r_reg.state == SSP_IDLE) && (r_reg.cnt != 2'h0);
    assign data_out = r_reg.data;
    assign busy = (r_reg.state != SSP_IDLE);

    // Next state of all registers
    always_comb
    begin
        logic [1:0] cnt_t;
        logic [4:0] len_t;
        cnt_t = r_reg.cnt;
        len_t = res_bits;
        r_next = r_reg;
        r_next.sclk_meta = sclk_in;
        r_next.sclk_sync = r_reg.sclk_meta;
        r_next.sclk_prev = r_reg.sclk_sync;
        // Clamp the width so a bad setting never indexes past the word
        if (len_t < MIN_BITS)
        begin
            len_t = MIN_BITS;
        end
        else if (len_t > MAX_BITS)
        begin
            len_t = MAX_BITS;
        end
        // Two-entry buffer: pop first, then append
        if (pop)
        begin
            r_next.shreg = r_reg.buf0;
            r_next.buf0 = r_reg.buf1;
            cnt_t = 2'(r_reg.cnt - 2'h1);
        end
        if (push)
        begin
            if (cnt_t == 2'h0)
            begin
                r_next.buf0 = pos_in;
            end
            else
            begin
                r_next.buf1 = pos_in;
            end
            cnt_t = 2'(cnt_t + 2'h1);
        end
        r_next.cnt = cnt_t;
        // Transfer sequencing
        unique case (r_reg.state)
            SSP_IDLE:
            begin
                r_next.data = DATA_IDLE;
                if (fall)
                begin
                    r_next.state = SSP_SHIFT;
                    r_next.mono = MONO_CYC;
                    r_next.word_len = len_t;
                    r_next.bits_left = len_t;
                end
            end
            SSP_SHIFT, SSP_DRAIN:
            begin
                if (fall || rise)
                begin
                    r_next.mono = MONO_CYC;
                end
                else if (r_reg.mono <= 11'h001)
                begin
                    // Monoflop ran out: release the register for loading
                    r_next.state = SSP_IDLE;
                    r_next.data = DATA_IDLE;
                end
                else
                begin
                    r_next.mono = 11'(r_reg.mono - 11'h001);
                end
                // Guard keeps the bit counter from wrapping past zero
                if (rise && r_reg.state == SSP_SHIFT && r_reg.bits_left != 5'h00)
                begin
                    r_next.data = cur_bit;
                    r_next.bits_left = 5'(r_reg.bits_left - 5'h01);
                end
                // Extra pulses beyond the word only clock out zeros
                if (rise && r_reg.bits_left == 5'h00)
                begin
                    r_next.state = SSP_DRAIN;
                    r_next.data = 1'b0;
                end
            end
            default:
            begin
                r_next.state = SSP_IDLE;
                r_next.data = DATA_IDLE;
            end
        endcase
    end

    // State register, synchronous reset
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            r_reg <= '0;
            r_reg.sclk_meta <= SCLK_IDLE;
            r_reg.sclk_sync <= SCLK_IDLE;
            r_reg.sclk_prev <= SCLK_IDLE;
            r_reg.state <= SSP_IDLE;
            r_reg.data <= DATA_IDLE;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    property p_load;
        @(posedge clk) disable iff (reset)
        (r_reg.state == SSP_IDLE && r_reg.cnt != 2'h0) |=> (r_reg.shreg == $past(r_reg.buf0));
    endproperty
    a_load: assert property (p_load) else $error("idle register not loaded");

    property p_frozen;
        @(posedge clk) disable iff (reset)
        (r_reg.state != SSP_IDLE) ##1 (r_reg.state != SSP_IDLE) |-> $stable(r_reg.shreg);
    endproperty
    a_frozen: assert property (p_frozen) else $error("register changed in transfer");

    property p_freeze;
        @(posedge clk) disable iff (reset)
        (r_reg.state == SSP_IDLE && fall) |=> (r_reg.state == SSP_SHIFT && busy);
    endproperty
    a_freeze: assert property (p_freeze) else $error("falling edge did not freeze");

    property p_bit;
        @(posedge clk) disable iff (reset)
        (r_reg.state == SSP_SHIFT && rise && r_reg.bits_left != 5'h00)
            |=> (data_out == $past(cur_bit));
    endproperty
    a_bit: assert property (p_bit) else $error("wrong data bit on rising edge");

    property p_retrig;
        @(posedge clk) disable iff (reset)
        (r_reg.state != SSP_IDLE && (rise || fall)) |=> (r_reg.mono == MONO_CYC);
    endproperty
    a_retrig: assert property (p_retrig) else $error("monoflop not retriggered");

    property p_drain_low;
        @(posedge clk) disable iff (reset)
        (r_reg.state == SSP_DRAIN) |-> (data_out == 1'b0);
    endproperty
    a_drain_low: assert property (p_drain_low) else $error("data not low after word");

    property p_expire;
        @(posedge clk) disable iff (reset)
        (r_reg.state != SSP_IDLE && r_reg.mono == 11'h001 && !rise && !fall)
            |=> (r_reg.state == SSP_IDLE) ##1 (data_out == 1'b1);
    endproperty
    a_expire: assert property (p_expire) else $error("monoflop expiry not honoured");

    property p_width;
        @(posedge clk) disable iff (reset)
        (r_reg.state == SSP_SHIFT) |-> (r_reg.word_len >= MIN_BITS && r_reg.word_len <= MAX_BITS);
    endproperty
    a_width: assert property (p_width) else $error("word width out of range");

    property p_idle_high;
        @(posedge clk) disable iff (reset)
        (r_reg.state == SSP_IDLE) |-> (data_out == 1'b1);
    endproperty
    a_idle_high: assert property (p_idle_high) else $error("idle data line not high");

    property p_hold_buf;
        @(posedge clk) disable iff (reset)
        (r_reg.state != SSP_IDLE) |=> (r_reg.cnt >= $past(r_reg.cnt));
    endproperty
    a_hold_buf: assert property (p_hold_buf) else $error("buffer drained in transfer");

    property p_word_end;
        @(posedge clk) disable iff (reset)
        (r_reg.state == SSP_SHIFT && rise && r_reg.bits_left == 5'h00)
            |=> (r_reg.state == SSP_DRAIN && data_out == 1'b0);
    endproperty
    a_word_end: assert property (p_word_end) else $error("data not low past word");
endmodule : ssp_slave

// ===== test/ssp_master.sv
// Serial master model: clock bursts on the link and capture of the data line
`timescale 1ns/1ps
module ssp_master
    import ssp_pkg::*;
(
    // Clock
    input wire logic clk,
    // Link pins
    output logic sclk,
    input wire logic data
);
    // Link clock rests high between frames
    initial sclk = SCLK_IDLE;

    // n pulses for the word plus one, so the low phase after the LSB shows up
    task automatic burst(input int n, input int gap, output logic [POS_W-1:0] word,
        output logic tail);
        word = '0;
        for (int i = 0; i <= n; i++)
        begin
            // Four clocks low and five high give a 180 ns link period
            @(negedge clk) sclk = 1'b0;
            repeat (4) @(negedge clk);
            // Capture just before the next rise, well after the design updates
            if (i > 0)
                word = {word[POS_W-2:0], data};
            sclk = 1'b1;
            repeat (4 + ((i == 0) ? gap : 0)) @(negedge clk);
        end
        repeat (4) @(negedge clk);
        tail = data;
    endtask : burst
endmodule : ssp_master

// ===== test/test_ssp_slave.sv
// Testbench for the serial position slave with a reference model
`timescale 1ns/1ps
module test_ssp_slave
    import ssp_pkg::*;
;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic sclk, data_out, pos_ready, busy, tail;
    logic pos_valid = 1'b0;
    logic [4:0] res_bits = MAX_BITS;
    logic [POS_W-1:0] pos_in = '0;
    logic [POS_W-1:0] word;
    int n_errors = 0;
    int comparisons = 0;
    int seed = 32'h67e7;
    int n, acc, sample;
    int model_q[$];

    // 50 MHz clock
    always #10 clk = ~clk;

    ssp_slave dut_u (.clk(clk), .reset(reset), .sclk_in(sclk), .data_out(data_out),
        .res_bits(res_bits), .pos_in(pos_in), .pos_valid(pos_valid),
        .pos_ready(pos_ready), .busy(busy));
    ssp_master m_u (.clk(clk), .sclk(sclk), .data(data_out));

    task automatic check(input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : check

    // Offer a word in each of k cycles only while there is room, so no refused word is withdrawn
    task automatic feed(input int k, output int taken);
        taken = 0;
        repeat (k)
        begin
            @(negedge clk);
            if (pos_ready === 1'b1)
            begin
                pos_in = POS_W'($random(seed));
                pos_valid = 1'b1;
                model_q.push_back(int'(pos_in));
                taken++;
            end
            else
            begin
                pos_valid = 1'b0;
            end
        end
        @(negedge clk) pos_valid = 1'b0;
    endtask : feed

    task automatic summarize();
        $display("comparisons=%0d mismatches=%0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : summarize

    // Main sequence: one frame per test, boundary widths in tests 0 and 2 to 4
    initial
    begin
        repeat (6) @(negedge clk);
        reset = 1'b0;
        @(negedge clk);
        check(1, data_out);
        check(0, busy);
        for (int t = 0; t < 8; t++)
        begin
            n = (t == 0 || t == 3) ? 18 : (t == 2 || t == 4) ? 2 : 2 + ({$random(seed)} % 17);
            // Settings out of range in tests 3 and 4 must clamp to the word limits
            res_bits = (t == 3) ? 5'h1f : (t == 4) ? 5'h00 : 5'(n);
            feed(3, acc);
            check(3, acc);
            repeat (5) @(negedge clk);
            sample = model_q[$];
            model_q.delete();
            // A long pause after the first pulse must not reload the register
            m_u.burst(n, (t == 1) ? 1000 : 0, word, tail);
            check(sample & ((32'h1 << n) - 1), word);
            check(0, tail);
            check(1, busy);
            feed(4, acc);
            check(BUF_DEPTH, acc);
            repeat (1190) @(negedge clk);
            check(1, busy);
            check(0, data_out);
            repeat (70) @(negedge clk);
            check(0, busy);
            check(1, data_out);
            $display("test %0d done, width %0d", t, n);
        end
        summarize();
    end
endmodule : test_ssp_slave
